// ### udcrc_crc.sv
`timescale 1ns/1ps
package udcrc_pkg;
    localparam int          CLK_NS    = 40;
    localparam logic [15:0] CRC_SEED  = 16'h4ABA;
    // link timing, plain defaults in ns
    localparam int          T_DVS_NS  = 70;
    localparam int          T_ACK_NS  = 20;
    localparam int          T_M0_NS   = 240;
    localparam int          T_M1_NS   = 160;
    localparam int          T_M2_NS   = 120;
    localparam logic [3:0]  DVS_CYC   = 4'((T_DVS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  ACK_CYC   = 4'((T_ACK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  M0_CYC    = 4'((T_M0_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  M1_CYC    = 4'((T_M1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  M2_CYC    = 4'((T_M2_NS + CLK_NS - 1) / CLK_NS);
    // register byte offsets
    localparam logic [7:0]  A_CTRL    = 8'h00;
    localparam logic [7:0]  A_TXDATA  = 8'h04;
    localparam logic [7:0]  A_RXDATA  = 8'h08;
    localparam logic [7:0]  A_STATUS  = 8'h0C;
    localparam logic [7:0]  A_CRC     = 8'h10;
    // control fields
    localparam int          CTRL_START = 0;
    localparam int          CTRL_DIRIN = 1;
    localparam int          CTRL_STOP  = 2;
    localparam int          CTRL_MODE  = 4;

    typedef enum logic [3:0] {
        S_IDLE      = 4'h0,
        S_OUT_WAIT  = 4'h1,
        S_OUT_SETUP = 4'h2,
        S_IN_RUN    = 4'h3,
        S_STOP      = 4'h4,
        S_CRC       = 4'h5,
        S_ACK       = 4'h6
    } udcrc_state_t;

    typedef struct packed {
        logic        dmack_n;
        logic        stop;
        logic        hstrobe;
        logic [15:0] d_out;
        logic        d_oe;
    } udcrc_pins_t;

    // word-parallel update of x16+x12+x5+1
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [15:0] d);
        logic [16:1] f;
        logic [15:0] n;
        f = '0;
        n = '0;
        for (int k = 1; k <= 4; k++) begin
            f[k] = d[k-1] ^ c[16-k];
        end
        for (int k = 5; k <= 11; k++) begin
            f[k] = d[k-1] ^ c[16-k] ^ f[k-4];
        end
        for (int k = 12; k <= 16; k++) begin
            f[k] = d[k-1] ^ c[16-k] ^ f[k-11] ^ f[k-4];
        end
        for (int b = 0; b <= 4; b++) begin
            n[b] = f[16-b];
        end
        for (int b = 5; b <= 11; b++) begin
            n[b] = f[16-b] ^ f[21-b];
        end
        for (int b = 12; b <= 15; b++) begin
            n[b] = f[16-b] ^ f[21-b] ^ f[28-b];
        end
        return n;
    endfunction

    // strobe setup per ultra mode; slower modes stretch it
    function automatic logic [3:0] mode_cycles(input logic [1:0] m);
        case (m)
            2'h0:    mode_cycles = M0_CYC;
            2'h1:    mode_cycles = M1_CYC;
            default: mode_cycles = M2_CYC;
        endcase
    endfunction
endpackage

module udcrc_crc_engine (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        load,
    input  wire logic        step,
    input  wire logic [15:0] data,
    output logic      [15:0] crc
);
    typedef struct packed {
        logic [15:0] crc;
    } udcrc_eng_t;

    udcrc_eng_t cur;
    udcrc_eng_t next_cur;

    always_comb begin
        next_cur = cur;
        if (load) begin
            next_cur.crc = udcrc_pkg::CRC_SEED;
        end else if (step) begin
            next_cur.crc = udcrc_pkg::crc_step(cur.crc, data);
        end
    end

    // sixteen-bit edge-triggered CRC register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cur <= '{crc: udcrc_pkg::CRC_SEED};
        end else begin
            cur <= next_cur;
        end
    end

    assign crc = cur.crc;

    a_eng_seed: assert property (@(posedge sys_clk) disable iff (!rst_b)
        load |=> crc == 16'h4ABA)
        else $error("crc not seeded");
    a_eng_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
        step && !load |=> crc == udcrc_pkg::crc_step($past(crc), $past(data)))
        else $error("crc step wrong");
    a_eng_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !step && !load |=> $stable(crc))
        else $error("crc changed without step");
endmodule

// ### udcrc_host.sv
`timescale 1ns/1ps
module udcrc_host (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        dmarq,
    input  wire logic        dev_strobe_rdy,
    input  wire logic [15:0] d_in,
    output logic      [15:0] d_out,
    output logic             d_oe,
    output logic             dmack_n,
    output logic             stop,
    output logic             hstrobe
);
    typedef struct packed {
        udcrc_pkg::udcrc_state_t st;
        udcrc_pkg::udcrc_pins_t  pins;
        logic [3:0]              cnt;
        logic [15:0]             words;
        logic [15:0]             rx;
        logic [15:0]             last_sent;
        logic                    dir_in;
        logic [1:0]              mode;
        logic                    dmarq_s1;
        logic                    dmarq_s2;
        logic                    rdy_s1;
        logic                    rdy_s2;
        logic                    rdy_s3;
        logic [15:0]             d_s1;
        logic [15:0]             d_s2;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
    } udcrc_host_t;

    udcrc_host_t cur;
    udcrc_host_t next_cur;
    logic        crc_load;
    logic        crc_step_en;
    logic [15:0] crc_data;
    logic [15:0] crc;
    logic        acc;
    logic        rdy_edge;

    udcrc_crc_engine u_crc (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .load    (crc_load),
        .step    (crc_step_en),
        .data    (crc_data),
        .crc     (crc)
    );

    always_comb begin
        next_cur         = cur;
        next_cur.pready  = 1'b0;
        next_cur.pslverr = 1'b0;
        // pins cross two flops before any logic looks at them
        next_cur.dmarq_s1 = dmarq;
        next_cur.dmarq_s2 = cur.dmarq_s1;
        next_cur.rdy_s1   = dev_strobe_rdy;
        next_cur.rdy_s2   = cur.rdy_s1;
        next_cur.rdy_s3   = cur.rdy_s2;
        next_cur.d_s1     = d_in;
        next_cur.d_s2     = cur.d_s1;
        crc_load    = 1'b0;
        crc_step_en = 1'b0;
        crc_data    = cur.pins.d_out;
        acc         = psel && penable && !cur.pready;
        rdy_edge    = cur.rdy_s2 ^ cur.rdy_s3;

        case (cur.st)
            udcrc_pkg::S_IDLE: begin
            end
            udcrc_pkg::S_OUT_WAIT: begin
                // device dropped its request: terminate
                if (!cur.dmarq_s2) begin
                    next_cur.st        = udcrc_pkg::S_STOP;
                    next_cur.pins.stop = 1'b1;
                end
            end
            udcrc_pkg::S_OUT_SETUP: begin
                if (!cur.dmarq_s2) begin
                    // word not strobed yet, so it never enters the crc
                    next_cur.st        = udcrc_pkg::S_STOP;
                    next_cur.pins.stop = 1'b1;
                end else if (cur.cnt != 4'h0) begin
                    next_cur.cnt = 4'(cur.cnt - 4'h1);
                end else if (!cur.rdy_s2) begin
                    next_cur.pins.hstrobe = ~cur.pins.hstrobe;
                    crc_step_en           = 1'b1;
                    next_cur.words        = 16'(cur.words + 16'h0001);
                    next_cur.st           = udcrc_pkg::S_OUT_WAIT;
                end
            end
            udcrc_pkg::S_IN_RUN: begin
                if (rdy_edge) begin
                    next_cur.rx    = cur.d_s2;
                    crc_data       = cur.d_s2;
                    crc_step_en    = 1'b1;
                    next_cur.words = 16'(cur.words + 16'h0001);
                end
                if (!cur.dmarq_s2) begin
                    next_cur.st        = udcrc_pkg::S_STOP;
                    next_cur.pins.stop = 1'b1;
                end
            end
            udcrc_pkg::S_STOP: begin
                // strobe edges seen here are returns, never data
                if (!cur.dmarq_s2) begin
                    next_cur.pins.hstrobe = 1'b1;
                    next_cur.pins.d_out   = crc;
                    next_cur.pins.d_oe    = 1'b1;
                    next_cur.cnt          = udcrc_pkg::DVS_CYC;
                    next_cur.st           = udcrc_pkg::S_CRC;
                end
            end
            udcrc_pkg::S_CRC: begin
                if (cur.cnt != 4'h0) begin
                    next_cur.cnt = 4'(cur.cnt - 4'h1);
                end else begin
                    next_cur.pins.dmack_n = 1'b1;
                    next_cur.last_sent    = crc;
                    next_cur.cnt          = udcrc_pkg::ACK_CYC;
                    next_cur.st           = udcrc_pkg::S_ACK;
                end
            end
            udcrc_pkg::S_ACK: begin
                // crc stays on the bus through the hold time
                if (cur.cnt != 4'h0) begin
                    next_cur.cnt = 4'(cur.cnt - 4'h1);
                end else begin
                    next_cur.pins.stop    = 1'b0;
                    next_cur.pins.d_oe    = 1'b0;
                    next_cur.pins.hstrobe = 1'b1;
                    next_cur.st           = udcrc_pkg::S_IDLE;
                end
            end
            default: begin
                next_cur.st = udcrc_pkg::S_IDLE;
            end
        endcase

        if (acc) begin
            next_cur.pready = 1'b1;
            next_cur.prdata = 32'h0000_0000;
            case (paddr)
                udcrc_pkg::A_CTRL: begin
                    if (pwrite) begin
                        next_cur.mode = pwdata[udcrc_pkg::CTRL_MODE +: 2];
                        if (pwdata[udcrc_pkg::CTRL_START]) begin
                            // also the path for a retry after error
                            if (cur.st == udcrc_pkg::S_IDLE && cur.dmarq_s2)
                            begin
                                crc_load = 1'b1;
                                next_cur.dir_in = pwdata[udcrc_pkg::CTRL_DIRIN];
                                next_cur.pins.dmack_n = 1'b0;
                                next_cur.pins.stop    = 1'b0;
                                next_cur.pins.d_oe    = 1'b0;
                                next_cur.words        = 16'h0000;
                                // in data-in the strobe pin is host ready
                                next_cur.pins.hstrobe =
                                    !pwdata[udcrc_pkg::CTRL_DIRIN];
                                next_cur.st = pwdata[udcrc_pkg::CTRL_DIRIN] ?
                                    udcrc_pkg::S_IN_RUN :
                                    udcrc_pkg::S_OUT_WAIT;
                            end else begin
                                next_cur.pslverr = 1'b1;
                            end
                        end else if (pwdata[udcrc_pkg::CTRL_STOP] &&
                                     (cur.st == udcrc_pkg::S_OUT_WAIT ||
                                      cur.st == udcrc_pkg::S_IN_RUN)) begin
                            next_cur.st        = udcrc_pkg::S_STOP;
                            next_cur.pins.stop = 1'b1;
                        end
                    end else begin
                        next_cur.prdata = {26'h0, cur.mode, 2'h0,
                                           cur.dir_in, 1'b0};
                    end
                end
                udcrc_pkg::A_TXDATA: begin
                    if (!pwrite) begin
                        next_cur.pslverr = 1'b1;
                    end else if (cur.st == udcrc_pkg::S_OUT_SETUP) begin
                        // word in flight: stall the bus
                        next_cur.pready = 1'b0;
                    end else if (cur.st == udcrc_pkg::S_OUT_WAIT &&
                                 cur.dmarq_s2) begin
                        next_cur.pins.d_out = pwdata[15:0];
                        next_cur.pins.d_oe  = 1'b1;
                        next_cur.cnt = udcrc_pkg::mode_cycles(cur.mode);
                        next_cur.st  = udcrc_pkg::S_OUT_SETUP;
                    end else begin
                        next_cur.pslverr = 1'b1;
                    end
                end
                udcrc_pkg::A_RXDATA: begin
                    next_cur.prdata = {16'h0, cur.rx};
                end
                udcrc_pkg::A_STATUS: begin
                    next_cur.prdata = {cur.words, 8'h00, 4'(cur.st), 2'h0,
                                       cur.dmarq_s2,
                                       cur.st != udcrc_pkg::S_IDLE};
                end
                udcrc_pkg::A_CRC: begin
                    next_cur.prdata = {cur.last_sent, crc};
                end
                default: begin
                    next_cur.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cur <= '{st:        udcrc_pkg::S_IDLE,
                     pins:      '{dmack_n: 1'b1, stop: 1'b0, hstrobe: 1'b1,
                                  d_out: 16'h0000, d_oe: 1'b0},
                     cnt:       4'h0,
                     words:     16'h0000,
                     rx:        16'h0000,
                     last_sent: 16'h0000,
                     dir_in:    1'b0,
                     mode:      2'h0,
                     dmarq_s1:  1'b0,
                     dmarq_s2:  1'b0,
                     rdy_s1:    1'b1,
                     rdy_s2:    1'b1,
                     rdy_s3:    1'b1,
                     d_s1:      16'h0000,
                     d_s2:      16'h0000,
                     prdata:    32'h0000_0000,
                     pready:    1'b0,
                     pslverr:   1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata  = cur.prdata;
    assign pready  = cur.pready;
    assign pslverr = cur.pslverr;
    assign d_out   = cur.pins.d_out;
    assign d_oe    = cur.pins.d_oe;
    assign dmack_n = cur.pins.dmack_n;
    assign stop    = cur.pins.stop;
    assign hstrobe = cur.pins.hstrobe;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    a_burst_seed: assert property ($fell(dmack_n) |-> crc == 16'h4ABA)
        else $error("burst did not start from seed");
    a_crc_driven: assert property ($rose(dmack_n) |-> d_oe && d_out == crc)
        else $error("crc not on bus at dmack negation");
    a_crc_setup: assert property ($rose(dmack_n) |-> $past(d_oe, 2) && $stable(d_out))
        else $error("crc not set up before dmack negation");
    // data-in start drops the strobe pin with dmack; that edge carries no word
    a_out_word: assert property ($changed(hstrobe) && !$past(stop) &&
        !dmack_n && !$past(dmack_n)
        |-> crc == udcrc_pkg::crc_step($past(crc), $past(d_out)))
        else $error("data edge did not fold word into crc");
    a_no_return: assert property ($changed(hstrobe) && $past(stop)
        |-> crc == $past(crc))
        else $error("termination strobe return updated crc");
    a_stop_bound: assert property ($rose(stop) && !dmarq
        |-> ##[1:20] $rose(dmack_n))
        else $error("burst end too slow");
    a_crc_frozen: assert property (stop && !dmack_n |=> stop throughout
        (crc == $past(crc))[*2])
        else $error("crc moved during termination");
    a_ack_release: assert property ($rose(dmack_n) |-> d_oe [*2] ##1 1'b1)
        else $error("crc released before hold");

    c_out_burst: cover property ($changed(hstrobe) && !dmack_n ##[1:200]
        $rose(dmack_n));
    c_in_burst: cover property (cur.st == udcrc_pkg::S_IN_RUN && rdy_edge);
    c_stall: cover property (psel && penable && !pready
        && cur.st == udcrc_pkg::S_OUT_SETUP);
endmodule

// ### udcrc_ref_pkg.sv
package udcrc_ref_pkg;
    // serial shift, bit 0 first; kept apart from the parallel form on purpose
    function automatic logic [15:0] udcrc_fold(input logic [15:0] c,
                                               input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 16; i++) begin
            r = {r[14:0], 1'h0} ^ ((r[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        end
        return r;
    endfunction
endpackage

// ### udcrc_dev_model.sv
`timescale 1ns/1ps
module udcrc_dev_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        cmd_start,
    input  wire logic        dmack_n,
    input  wire logic        stop,
    input  wire logic        hstrobe,
    input  wire logic [15:0] d_out,
    output logic             dmarq,
    output logic             dev_strobe_rdy,
    output logic      [15:0] d_in,
    output logic             match,
    output logic             err_rec,
    output int               bursts
);
    logic [15:0] crc;
    logic [15:0] d_val;
    logic        drv;
    logic        dir_in;
    logic        p_ack;
    logic        p_hs;
    logic        p_rdy;
    int          strobes;
    int          err_first;
    logic [7:0]  err_reg;
    logic [3:0]  sense_key;
    logic        sense_req;

    // released bus shows the inverse of the last word, never a stale copy
    assign d_in = drv ? d_val : ~d_val;

    initial begin
        dmarq = 1'h0;
        dev_strobe_rdy = 1'h1;
        drv = 1'h0;
        d_val = 16'h0000;
        dir_in = 1'h0;
        sense_req = 1'h0;
    end

    always @(posedge sys_clk) begin
        p_ack <= dmack_n;
        p_hs <= hstrobe;
        p_rdy <= dev_strobe_rdy;
        if (!rst_b || cmd_start) begin
            err_rec <= 1'h0;
            err_reg <= 8'h00;
            sense_key <= 4'h0;
        end
        if (!rst_b) begin
            bursts <= 0;
            match <= 1'h0;
        end else if (p_ack && !dmack_n) begin
            crc <= udcrc_pkg::CRC_SEED;
            strobes <= 0;
        end else if (!dmack_n && !stop && !dir_in && hstrobe !== p_hs) begin
            // surplus words still fold in, nothing is stored
            crc <= udcrc_ref_pkg::udcrc_fold(crc, d_out);
            strobes <= strobes + 1;
        end else if (!dmack_n && dir_in && dev_strobe_rdy !== p_rdy) begin
            crc <= udcrc_ref_pkg::udcrc_fold(crc, d_in);
        end else if (!p_ack && dmack_n) begin
            match <= d_out === crc;
            bursts <= bursts + 1;
            if (d_out !== crc && !err_rec) begin
                err_rec <= 1'h1;
                err_first <= bursts;
                err_reg <= 8'h84;
                // sense key records the error: 4'hB if sense_req, else 4'h4
                sense_key <= sense_req ? 4'hB : 4'h4;
            end
        end
    end

    task automatic wait_ack(input logic lvl);
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (dmack_n !== lvl && k < 4000);
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic out_burst(input int n);
        int k;
        k = 0;
        dir_in <= 1'h0;
        dmarq <= 1'h1;
        wait_ack(1'h0);
        dev_strobe_rdy <= 1'h0;
        while (strobes < n && k < 4000) begin
            // a slow device pauses now and then
            if (k > 0 && $urandom_range(7) == 0) begin
                dev_strobe_rdy <= 1'h1;
                repeat (6) @(posedge sys_clk);
                dev_strobe_rdy <= 1'h0;
            end
            @(posedge sys_clk);
            k++;
        end
        dev_strobe_rdy <= 1'h1;
        repeat (3) @(posedge sys_clk);
        dmarq <= 1'h0;
        wait_ack(1'h1);
    endtask

    task automatic in_burst(input logic [63:0] w, input int n);
        dir_in <= 1'h1;
        drv <= 1'h1;
        dmarq <= 1'h1;
        wait_ack(1'h0);
        for (int i = 0; i < n; i++) begin
            while (hstrobe !== 1'h0)
                @(posedge sys_clk);
            d_val <= w[16*i +: 16];
            @(posedge sys_clk);
            dev_strobe_rdy <= ~dev_strobe_rdy;
            repeat (3) @(posedge sys_clk);
        end
        dmarq <= 1'h0;
        drv <= 1'h0;
        wait_ack(1'h1);
        dev_strobe_rdy <= 1'h1;
    endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk, rst_b, psel, penable, pwrite, cmd_start, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, dmarq, dev_strobe_rdy, d_oe;
    logic        dmack_n, stop, hstrobe, match, err_rec;
    logic [15:0] d_in, d_out;
    int          bursts, fail_count, cmp_count;

    udcrc_host udcrc_host_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dmarq(dmarq), .dev_strobe_rdy(dev_strobe_rdy),
        .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .dmack_n(dmack_n),
        .stop(stop), .hstrobe(hstrobe));

    udcrc_dev_model udcrc_dev_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .cmd_start(cmd_start), .dmack_n(dmack_n), .stop(stop),
        .hstrobe(hstrobe), .d_out(d_out), .dmarq(dmarq),
        .dev_strobe_rdy(dev_strobe_rdy), .d_in(d_in), .match(match),
        .err_rec(err_rec), .bursts(bursts));

    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic print_verdict();
        $display("summary: %0d compares, %0d mismatches", cmp_count,
                 fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'h1 && k < 4000);
        check(32'(k < 4000), 32'h1, "bus answer");
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic run_burst(input logic dir, input logic [1:0] m);
        int n;
        int b;
        logic [63:0] w;
        logic [15:0] e;
        n = $urandom_range(4, 1);
        w = {$urandom, $urandom};
        e = udcrc_pkg::CRC_SEED;
        b = bursts;
        for (int i = 0; i < n; i++) begin
            e = udcrc_ref_pkg::udcrc_fold(e, w[16*i +: 16]);
        end
        fork
            begin
                if (dir) begin
                    udcrc_dev_model_inst.in_burst(w, n);
                end else begin
                    udcrc_dev_model_inst.out_burst(n);
                end
            end
            begin
                repeat (4) @(posedge sys_clk);
                apb(1'h1, udcrc_pkg::A_CTRL, {26'h0, m, 2'h0, dir, 1'h1});
                check(32'(er), 32'h0, "start refused");
                for (int i = 0; i < n && !dir; i++) begin
                    apb(1'h1, udcrc_pkg::A_TXDATA, {16'h0, w[16*i +: 16]});
                    check(32'(er), 32'h0, "word refused");
                end
            end
        join
        check(32'(bursts), 32'(b + 1), "burst count");
        check(32'(match), 32'h1, "device crc compare");
        apb(1'h0, udcrc_pkg::A_CRC, 32'h0);
        check({16'h0, rd[31:16]}, {16'h0, e}, "crc sent");
        if (dir) begin
            apb(1'h0, udcrc_pkg::A_RXDATA, 32'h0);
            check({16'h0, rd[15:0]}, {16'h0, w[16*(n-1) +: 16]}, "rx word");
        end
        $display("test burst dir %0d mode %0d words %0d done", dir, m, n);
    endtask

    initial begin
        rst_b = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cmd_start = 1'h0;
        fail_count = 0;
        cmp_count = 0;
        void'($urandom(20));
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'h1;
        apb(1'h0, udcrc_pkg::A_CRC, 32'h0);
        check({16'h0, rd[15:0]}, 32'h4ABA, "seed after reset");
        apb(1'h0, udcrc_pkg::A_STATUS, 32'h0);
        check({24'h0, rd[7:0]}, 32'h0, "idle status");
        apb(1'h0, 8'h14, 32'h0);
        check(32'(er), 32'h1, "unmapped read");
        apb(1'h0, udcrc_pkg::A_TXDATA, 32'h0);
        check(32'(er), 32'h1, "word register read");
        apb(1'h1, udcrc_pkg::A_TXDATA, 32'h1234);
        check(32'(er), 32'h1, "word while idle");
        apb(1'h1, udcrc_pkg::A_CTRL, 32'h1);
        check(32'(er), 32'h1, "start without request");
        $display("test refusals done");
        cmd_start <= 1'h1;
        @(posedge sys_clk);
        cmd_start <= 1'h0;
        for (int r = 0; r < 2; r++) begin
            for (int m = 0; m < 3; m++) begin
                for (int d = 0; d < 2; d++) begin
                    run_burst(1'(d), 2'(m));
                end
            end
        end
        check(32'(err_rec), 32'h0, "device error record");
        check({24'h0, udcrc_dev_model_inst.err_reg}, 32'h0, "error reg");
        check({28'h0, udcrc_dev_model_inst.sense_key}, 32'h0, "sense key");
        print_verdict();
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        fail_count++;
        $display("ERROR at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
